//--- vfr_pkg.sv
`default_nettype none
package vfr_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] A_FMAX   = 8'h00;
   localparam logic [7:0] A_FMIN   = 8'h04;
   localparam logic [7:0] A_MIN_OUT_VOLT   = 8'h08;
   localparam logic [7:0] A_UPCT   = 8'h0c;
   localparam logic [7:0] A_LPCT   = 8'h10;
   localparam logic [7:0] A_ACC1   = 8'h14;
   localparam logic [7:0] A_DEC1   = 8'h18;
   localparam logic [7:0] A_ACC2   = 8'h1c;
   localparam logic [7:0] A_DEC2   = 8'h20;
   localparam logic [7:0] A_TUNIT  = 8'h24;
   localparam logic [7:0] A_JACC   = 8'h28;
   localparam logic [7:0] A_JDEC   = 8'h2c;
   localparam logic [7:0] A_JFREQ  = 8'h30;
   localparam logic [7:0] A_AUTO   = 8'h34;
   localparam logic [7:0] A_SACC   = 8'h38;
   localparam logic [7:0] A_SDEC   = 8'h3c;
   localparam logic [7:0] A_CMD    = 8'h40;
   localparam logic [7:0] A_CTRL   = 8'h44;
   localparam logic [7:0] A_TFUNC  = 8'h48;
   localparam logic [7:0] A_STATUS = 8'h4c;
   localparam logic [7:0] A_OFREQ  = 8'h50;
   // ----------------------------------------------------------------
   // reset values and legal ranges
   // ----------------------------------------------------------------
   localparam logic [15:0] R_FMAX    = 16'h1770;
   localparam logic [15:0] R_FMIN    = 16'h0096;
   localparam logic [15:0] R_MIN_OUT_VOLT_LO = 16'h0064;
   localparam logic [15:0] R_MIN_OUT_VOLT_HI = 16'h00c8;
   localparam logic [15:0] R_UPCT    = 16'h044c;
   localparam logic [15:0] R_TIME    = 16'h0064;
   localparam logic [15:0] R_JTIME   = 16'h000a;
   localparam logic [15:0] R_JFREQ   = 16'h0258;
   localparam logic [15:0] FMAX_LO   = 16'h1388;
   localparam logic [15:0] F_HI      = 16'hea60;
   localparam logic [15:0] FMIN_LO   = 16'h000a;
   localparam logic [15:0] ONE       = 16'h0001;
   localparam logic [15:0] MAX_OUT_VOLT_LO   = 16'h09f6;
   localparam logic [15:0] MAX_OUT_VOLT_HI   = 16'h13ec;
   localparam logic [15:0] PCT_HI    = 16'h04b0;
   localparam logic [15:0] T_HI_C    = 16'h1770;
   localparam logic [15:0] T_HI_F    = 16'hea60;
   localparam logic [15:0] S_HI_C    = 16'h0064;
   localparam logic [15:0] S_HI_F    = 16'h03e8;
   localparam logic [15:0] AUTO_HI   = 16'h0004;
   localparam logic [15:0] CTRL_HI   = 16'h0003;
   localparam logic [15:0] TFUNC_HI  = 16'h00ff;
   localparam logic [31:0] PCT_DIV   = 32'h0000_03e8;
   localparam logic [3:0]  FUNC_JOG   = 4'h6;
   localparam logic [3:0]  FUNC_RAMP2 = 4'h7;
   localparam logic [2:0]  AUTO_LIN  = 3'h0;
   localparam logic [2:0]  AUTO_ACC  = 3'h1;
   localparam logic [2:0]  AUTO_DEC  = 3'h2;
   localparam logic [2:0]  AUTO_LOAD = 3'h3;
   localparam logic [2:0]  AUTO_SET  = 3'h4;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ      = 125;
   localparam int FINE_UNIT_US = 10000;
   localparam int UNIT_RATIO   = 10;
   localparam int SUB_SHIFT    = 16;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_STOP = 4'b0001,
      ST_RUN  = 4'b0010,
      ST_JOG  = 4'b0100,
      ST_JDN  = 4'b1000
   } vfr_state_t;
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } vfr_axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } vfr_axi_rsp_t;
endpackage
`default_nettype wire

//--- vfr_ramp_gen.sv
// Functional notes
// - minimum frequency 0.10..600.0 Hz, default 1.50
// - minimum voltage range and default per series
// - upper limit is fmax times percent over 1000 (0.1 % units)
// - lower limit is fmax times percent over 1000 (0.1 % units)
// - output frequency above upper limit is clamped to it on the next cycle
// - below lower limit clamps; below minimum, no output
// - two time pairs, terminal function 7 selects second
// - time unit 0 is 0.1 s, 1 is 0.01 s
// - accel time spans 0 Hz to fmax
// - decel time spans fmax to 0 Hz
// - jog ramps from minimum to jog frequency
// - jog release ramps down with jog decel time
// - jog only from stop; run ignored while jogging
// - auto ramp modes 0 to 4
// - mode 4 never faster than set times
// - s-curve zero disables, up to 10.0 enables
// - accel total equals accel time plus s-curve
// - decel total equals decel time plus s-curve
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vfr_ramp_gen #(
   parameter bit HIGH_V        = 1'b0,
   parameter int FINE_UNIT_CYC = vfr_pkg::FINE_UNIT_US * vfr_pkg::CLK_MHZ
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   input  wire vfr_pkg::vfr_axi_req_t axi_req_i,
   output var  vfr_pkg::vfr_axi_rsp_t axi_rsp_o,
   input  wire logic [1:0]            multi_input_terminal_i,
   input  wire logic                  load_limit_i,
   output var  logic [15:0]           freq_o,
   output var  logic                  out_en_o,
   output var  logic                  dir_o
);
   import vfr_pkg::*;

   localparam logic [31:0] FINE_DIV   = 32'(FINE_UNIT_CYC >> SUB_SHIFT);
   localparam logic [31:0] COARSE_DIV = 32'((FINE_UNIT_CYC * UNIT_RATIO) >> SUB_SHIFT);
   localparam logic [15:0] MIN_OUT_VOLT_HI    = HIGH_V ? MAX_OUT_VOLT_HI : MAX_OUT_VOLT_LO;

   if (FINE_UNIT_CYC < (1 << SUB_SHIFT)) begin : g_chk
      $error("FINE_UNIT_CYC too small for the sub-tick divider");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      vfr_axi_rsp_t rsp;
      logic         aw_have;
      logic [7:0]   awa;
      logic         w_have;
      logic [31:0]  wd;
      logic [3:0]   ws;
      logic [15:0]  fmax, fmin, min_out_volt, upct, lpct;
      logic [15:0]  acc1, dec1, acc2, dec2;
      logic         tunit;
      logic [15:0]  jacc, jdec, jfreq;
      logic [2:0]   auto;
      logic [15:0]  sacc, sdec, cmd;
      logic         run, dir;
      logic [7:0]   tfunc;
      logic [2:0]   s1, s2, s3, f;
      vfr_state_t   st;
      logic [15:0]  upper, lower, tgt, freq;
      logic         out_en, ramping, sel2;
      logic [32:0]  acc;
      logic [31:0]  div;
   } vfr_s_t;

   function automatic vfr_s_t rst_val();
      vfr_s_t r;
      r             = '0;
      r.rsp.awready = 1'b1;
      r.rsp.wready  = 1'b1;
      r.rsp.arready = 1'b1;
      r.fmax        = R_FMAX;
      r.fmin        = R_FMIN;
      r.min_out_volt        = HIGH_V ? R_MIN_OUT_VOLT_HI : R_MIN_OUT_VOLT_LO;
      r.upct        = R_UPCT;
      // limits leave reset already matching the reset percentages
      r.upper       = 16'((32'(R_FMAX) * 32'(R_UPCT)) / PCT_DIV);
      r.acc1        = R_TIME;
      r.dec1        = R_TIME;
      r.acc2        = R_TIME;
      r.dec2        = R_TIME;
      r.jacc        = R_JTIME;
      r.jdec        = R_JTIME;
      r.jfreq       = R_JFREQ;
      r.st          = ST_STOP;
      return r;
   endfunction

   localparam vfr_s_t RST = rst_val();

   function automatic logic [31:0] rdreg(input vfr_s_t x, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         A_FMAX:   v = {16'h0, x.fmax};
         A_FMIN:   v = {16'h0, x.fmin};
         A_MIN_OUT_VOLT:   v = {16'h0, x.min_out_volt};
         A_UPCT:   v = {16'h0, x.upct};
         A_LPCT:   v = {16'h0, x.lpct};
         A_ACC1:   v = {16'h0, x.acc1};
         A_DEC1:   v = {16'h0, x.dec1};
         A_ACC2:   v = {16'h0, x.acc2};
         A_DEC2:   v = {16'h0, x.dec2};
         A_TUNIT:  v = {31'h0, x.tunit};
         A_JACC:   v = {16'h0, x.jacc};
         A_JDEC:   v = {16'h0, x.jdec};
         A_JFREQ:  v = {16'h0, x.jfreq};
         A_AUTO:   v = {29'h0, x.auto};
         A_SACC:   v = {16'h0, x.sacc};
         A_SDEC:   v = {16'h0, x.sdec};
         A_CMD:    v = {16'h0, x.cmd};
         A_CTRL:   v = {30'h0, x.dir, x.run};
         A_TFUNC:  v = {24'h0, x.tfunc};
         A_STATUS: v = {24'h0, x.sel2, x.upct < x.lpct, x.ramping, x.out_en, x.st};
         A_OFREQ:  v = {16'h0, x.freq};
         default:  v = 32'h0;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a <= A_OFREQ) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++) begin
         if (b[i]) begin
            m[8*i +: 8] = d[8*i +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic in_rng(input logic [31:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
      return (v[31:16] == 16'h0) && (v[15:0] >= lo) && (v[15:0] <= hi);
   endfunction

   vfr_s_t      s;
   vfr_s_t      n;
   logic [31:0] mv;
   logic [15:0] thi;
   logic [15:0] shi;
   logic        ok;
   logic        jog_in;
   logic        ramp2;
   logic        up;
   logic        jogst;
   logic        auto_dir;
   logic        pause;
   logic [15:0] tsel;
   logic [15:0] ssel;
   logic [15:0] tgt_c;
   logic [32:0] thr;
   logic [32:0] acc_n;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n        = s;
      mv       = merge(rdreg(s, s.awa), s.wd, s.ws);
      thi      = s.tunit ? T_HI_F : T_HI_C;
      shi      = s.tunit ? S_HI_F : S_HI_C;
      ok       = 1'b0;
      // terminal inputs: change counts once second and third stage agree
      n.s1     = {load_limit_i, multi_input_terminal_i};
      n.s2     = s.s1;
      n.s3     = s.s2;
      n.f      = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.f);

      // bus write channel
      if (axi_req_i.awvalid && s.rsp.awready) begin
         n.aw_have = 1'b1;
         n.awa     = axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && s.rsp.wready) begin
         n.w_have = 1'b1;
         n.wd     = axi_req_i.wdata;
         n.ws     = axi_req_i.wstrb;
      end
      if (s.rsp.bvalid && axi_req_i.bready) begin
         n.rsp.bvalid = 1'b0;
      end
      if (s.aw_have && s.w_have && !s.rsp.bvalid) begin
         n.aw_have = 1'b0;
         n.w_have  = 1'b0;
         case (s.awa)
            A_FMAX:  ok = in_rng(mv, FMAX_LO, F_HI);
            A_FMIN:  ok = in_rng(mv, FMIN_LO, F_HI);
            A_MIN_OUT_VOLT:  ok = in_rng(mv, ONE, MIN_OUT_VOLT_HI);
            A_UPCT:  ok = in_rng(mv, ONE, PCT_HI);
            A_LPCT:  ok = in_rng(mv, 16'h0, PCT_HI);
            A_ACC1, A_DEC1, A_ACC2, A_DEC2, A_JACC, A_JDEC: ok = in_rng(mv, ONE, thi);
            A_TUNIT: ok = in_rng(mv, 16'h0, ONE);
            A_JFREQ: ok = in_rng(mv, FMIN_LO, s.fmax);
            A_AUTO:  ok = in_rng(mv, 16'h0, AUTO_HI);
            A_SACC, A_SDEC: ok = in_rng(mv, 16'h0, shi);
            A_CMD:   ok = in_rng(mv, 16'h0, F_HI);
            A_CTRL:  ok = in_rng(mv, 16'h0, CTRL_HI);
            A_TFUNC: ok = in_rng(mv, 16'h0, TFUNC_HI);
            default: ok = 1'b0;
         endcase
         if (ok) begin
            case (s.awa)
               A_FMAX:  n.fmax  = mv[15:0];
               A_FMIN:  n.fmin  = mv[15:0];
               A_MIN_OUT_VOLT:  n.min_out_volt  = mv[15:0];
               A_UPCT:  n.upct  = mv[15:0];
               A_LPCT:  n.lpct  = mv[15:0];
               A_ACC1:  n.acc1  = mv[15:0];
               A_DEC1:  n.dec1  = mv[15:0];
               A_ACC2:  n.acc2  = mv[15:0];
               A_DEC2:  n.dec2  = mv[15:0];
               A_TUNIT: n.tunit = mv[0];
               A_JACC:  n.jacc  = mv[15:0];
               A_JDEC:  n.jdec  = mv[15:0];
               A_JFREQ: n.jfreq = mv[15:0];
               A_AUTO:  n.auto  = mv[2:0];
               A_SACC:  n.sacc  = mv[15:0];
               A_SDEC:  n.sdec  = mv[15:0];
               A_CMD:   n.cmd   = mv[15:0];
               A_CTRL: begin
                  n.run = mv[0];
                  n.dir = mv[1];
               end
               A_TFUNC: n.tfunc = mv[7:0];
               default: n.tfunc = s.tfunc;
            endcase
         end
         n.rsp.bvalid = 1'b1;
         n.rsp.bresp  = ok ? RESP_OK : RESP_ERR;
      end
      n.rsp.awready = !n.aw_have;
      n.rsp.wready  = !n.w_have;

      // bus read channel
      if (s.rsp.rvalid && axi_req_i.rready) begin
         n.rsp.rvalid = 1'b0;
      end
      if (axi_req_i.arvalid && s.rsp.arready) begin
         n.rsp.rvalid = 1'b1;
         n.rsp.rdata  = rdreg(s, axi_req_i.araddr);
         n.rsp.rresp  = mapped(axi_req_i.araddr) ? RESP_OK : RESP_ERR;
      end
      n.rsp.arready = !n.rsp.rvalid;

      // ----------------------------------------------------------------
      // limits and terminal decode
      // ----------------------------------------------------------------
      // upper limit
      n.upper = 16'((32'(s.fmax) * 32'(s.upct)) / PCT_DIV);
      n.lower = 16'((32'(s.fmax) * 32'(s.lpct)) / PCT_DIV);
      jog_in  = (s.f[0] && (s.tfunc[3:0] == FUNC_JOG)) || (s.f[1] && (s.tfunc[7:4] == FUNC_JOG));
      ramp2   = (s.f[0] && (s.tfunc[3:0] == FUNC_RAMP2))
              || (s.f[1] && (s.tfunc[7:4] == FUNC_RAMP2));
      n.sel2  = ramp2;

      // ----------------------------------------------------------------
      // operating state and target
      // ----------------------------------------------------------------
      tgt_c = 16'h0;
      case (s.st)
         ST_STOP: begin
            if (jog_in && (s.freq == 16'h0)) begin
               n.st = ST_JOG;
            end else if (s.run) begin
               n.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!s.run && (s.freq == 16'h0)) begin
               n.st = ST_STOP;
            end
            if (!s.run || (s.cmd < s.fmin)) begin
               tgt_c = 16'h0;
            end else if (s.cmd < s.lower) begin
               tgt_c = s.lower;
            end else if (s.cmd > s.upper) begin
               tgt_c = s.upper;
            end else begin
               tgt_c = s.cmd;
            end
         end
         ST_JOG: begin
            if (!jog_in) begin
               n.st = ST_JDN;
            end
            tgt_c = (s.jfreq > s.upper) ? s.upper : s.jfreq;
         end
         ST_JDN: begin
            if (s.freq == 16'h0) begin
               n.st = ST_STOP;
            end
         end
         default: n.st = ST_STOP;
      endcase
      n.tgt = tgt_c;

      // ----------------------------------------------------------------
      // ramp
      // ----------------------------------------------------------------
      up       = s.freq < s.tgt;
      jogst    = (s.st == ST_JOG) || (s.st == ST_JDN);
      auto_dir = up ? ((s.auto == AUTO_ACC) || (s.auto >= AUTO_LOAD))
                    : ((s.auto == AUTO_DEC) || (s.auto >= AUTO_LOAD));
      if (jogst) begin
         tsel = up ? s.jacc : s.jdec;
      end else if (up) begin
         tsel = ramp2 ? s.acc2 : s.acc1;
      end else begin
         tsel = ramp2 ? s.dec2 : s.dec1;
      end
      ssel = (jogst || (auto_dir && (s.auto != AUTO_SET))) ? 16'h0 : (up ? s.sacc : s.sdec);
      thr  = {({1'b0, tsel} + {1'b0, ssel}), 16'h0};
      // auto pauses the ramp on load sense, but drops the s-curve in modes 1 to 3
      pause = auto_dir && (s.auto != AUTO_LIN) && s.f[2];
      acc_n = s.acc + {17'h0, s.fmax};

      if (s.div == 32'h0) begin
         n.div = (s.tunit ? FINE_DIV : COARSE_DIV) - 32'h1;
      end else begin
         n.div = s.div - 32'h1;
      end

      if (s.freq > s.upper) begin
         n.freq = s.upper;
         n.acc  = 33'h0;
      end else if (s.freq == s.tgt) begin
         n.acc = 33'h0;
      end else if (s.freq == 16'h0) begin
         n.freq = (s.fmin > s.tgt) ? s.tgt : s.fmin;
      end else if ((s.div == 32'h0) && !pause) begin
         if (acc_n >= thr) begin
            n.acc = acc_n - thr;
            if (up) begin
               n.freq = s.freq + 16'h1;
            end else if ((s.tgt == 16'h0) && (s.freq <= s.fmin)) begin
               n.freq = 16'h0;
            end else begin
               n.freq = s.freq - 16'h1;
            end
         end else begin
            n.acc = acc_n;
         end
      end
      n.out_en  = n.freq != 16'h0;
      n.ramping = n.freq != n.tgt;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   assign axi_rsp_o = s.rsp;
   assign freq_o    = s.freq;
   assign out_en_o  = s.out_en;
   assign dir_o     = s.dir;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence q_jog_enter;
      $rose(s.st == ST_JOG);
   endsequence
   sequence q_jog_fit;
      (s.jfreq >= s.fmin) && (s.upper >= s.jfreq) && $stable(s.fmin);
   endsequence

   property p_fmin;
      (s.fmin >= FMIN_LO) && (s.fmin <= F_HI);
   endproperty
   property p_min_out_volt;
      (s.min_out_volt >= ONE) && (s.min_out_volt <= MIN_OUT_VOLT_HI);
   endproperty
   property p_upper;
      1'b1 |=> s.upper == 16'((32'($past(s.fmax)) * 32'($past(s.upct))) / PCT_DIV);
   endproperty
   property p_clamp;
      s.freq > s.upper |=> s.freq == $past(s.upper);
   endproperty
   property p_floor;
      (s.st == ST_RUN) ##1 ((s.tgt != 16'h0) && (s.upct >= s.lpct)) |-> s.tgt >= $past(s.lower);
   endproperty
   property p_ready;
      (s.st == ST_STOP) [*3] |-> !out_en_o && (freq_o == 16'h0);
   endproperty
   property p_jog_stop;
      q_jog_enter |-> ($past(s.st) == ST_STOP) && ($past(s.freq) == 16'h0);
   endproperty
   property p_jog_min;
      q_jog_enter ##0 q_jog_fit |-> ##2 (s.freq == s.fmin);
   endproperty
   property p_jog_rel;
      (s.st == ST_JOG) && !jog_in |=> (s.st == ST_JDN) && (s.tgt == $past(s.tgt));
   endproperty
   property p_step;
      $changed(s.freq) |-> ($past(s.freq) == 16'h0) || (s.freq == 16'h0)
         || (s.freq == $past(s.upper)) || (s.freq == $past(s.freq) + 16'h1)
         || (s.freq == $past(s.freq) - 16'h1);
   endproperty

   a_fmin: assert property (p_fmin) else $error("min frequency out of range");
   a_min_out_volt: assert property (p_min_out_volt) else $error("min voltage out of range");
   a_upper: assert property (p_upper) else $error("upper limit wrong");
   a_clamp: assert property (p_clamp) else $error("frequency above upper limit");
   a_floor: assert property (p_floor) else $error("target below lower limit");
   a_ready: assert property (p_ready) else $error("output while stopped");
   a_jog_stop: assert property (p_jog_stop) else $error("jog entered while moving");
   a_jog_min: assert property (p_jog_min) else $error("jog did not start at minimum");
   a_jog_rel: assert property (p_jog_rel) else $error("jog release not handled");
   a_step: assert property (p_step) else $error("frequency step too large");
endmodule // vfr_ramp_gen
`default_nettype wire

//--- vfr_ramp_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vfr_ramp_gen_tb;
   import vfr_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_b_i = 1'b0;
   vfr_axi_req_t req = '0;
   vfr_axi_rsp_t rsp;
   logic [1:0]   term = 2'h0;
   logic         load = 1'b0;
   logic [1:0]   mt;
   logic         ld;
   logic [15:0]  freq_o;
   logic         out_en_o;
   logic         dir_o;
   int           err_total = 0;
   int           cmp_count = 0;
   int           cyc = 0;
   logic [7:0]   ra[9] = '{A_FMAX, A_FMIN, A_MIN_OUT_VOLT, A_UPCT, A_ACC1, A_JACC, A_JFREQ, A_TUNIT, A_SACC};
   logic [15:0]  rv[9] = '{R_FMAX, R_FMIN, R_MIN_OUT_VOLT_LO, R_UPCT, R_TIME, R_JTIME, R_JFREQ, 0, 0};
   logic [7:0]   ca[10] = '{A_TUNIT, A_ACC1, A_DEC1, A_UPCT, A_LPCT, A_JACC, A_JDEC, A_JFREQ,
                            A_ACC2, A_TFUNC};
   logic [15:0]  cd[10] = '{1, 1, 1, 100, 50, 1, 1, 200, 3, 16'h0076};
   always #4 clk_i = ~clk_i;
   vfr_ramp_gen #(.FINE_UNIT_CYC(65536)) vfr_ramp_gen_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .axi_req_i(req), .axi_rsp_o(rsp), .multi_input_terminal_i(mt), .load_limit_i(ld),
      .freq_o(freq_o), .out_en_o(out_en_o), .dir_o(dir_o));
   vfr_term_model vfr_term_model_inst (.clk_i(clk_i), .term_req_i(term), .load_req_i(load),
      .term_o(mt), .load_o(ld));
   task automatic test_done;
      $display("mismatches %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cv(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %0d got %0d", n, e, g);
      end
   endtask
   task automatic cr(input string n, input logic [1:0] e, input logic [1:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s resp exp %0d got %0d", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
      @(posedge clk_i);
      req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:{16'h0, d}, wstrb:4'hf,
               bready:1'b1, default:'0};
      do begin
         @(posedge clk_i);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      r = rsp.bresp;
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
      do begin
         @(posedge clk_i);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   // expected clamped target for the limits set below
   function automatic logic [15:0] tgt(input int c);
      if (c < int'(R_FMIN)) return 16'h0;
      if (c < int'(R_FMAX) * 50 / 1000) return 16'(int'(R_FMAX) * 50 / 1000);
      if (c > int'(R_FMAX) * 100 / 1000) return 16'(int'(R_FMAX) * 100 / 1000);
      return 16'(c);
   endfunction
   task automatic wt(input logic [15:0] e, output int n);
      n = 0;
      while (freq_o !== e && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
      cv("freq", e, freq_o);
      cv("out_en", e != 0, out_en_o);
   endtask
   // one 100-step ramp, t is time plus s-curve in 0.01 s
   task automatic rp(input logic [15:0] x, input int t);
      logic [1:0] r;
      int         n;
      int         e;
      e = 100 * t * 65536 / int'(R_FMAX);
      wr(A_CMD, x, r);
      wt(x, n);
      cv("ramp_len", 1, n >= e - 15 && n <= e + 25);
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         $display("[FAIL] timeout exp 0 got 1");
         test_done();
      end
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      int          c;
      void'($urandom(35109));
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(ra[i], d, r);
         cv("reset_val", rv[i], d);
      end
      wr(A_FMIN, 16'h0005, r);
      cr("fmin", RESP_ERR, r);
      wr(A_UPCT, 16'h04b1, r);
      cr("upct", RESP_ERR, r);
      wr(A_TUNIT, 16'h0002, r);
      cr("tunit", RESP_ERR, r);
      rd(8'h60, d, r);
      cr("unmapped", RESP_ERR, r);
      for (int i = 0; i < 6; i++) begin
         wr(A_AUTO, 16'(i), r);
         cr("auto", (i < 5) ? RESP_OK : RESP_ERR, r);
      end
      $display("test access done");
      for (int i = 0; i < 10; i++) begin
         wr(ca[i], cd[i], r);
         cr("cfg", RESP_OK, r);
      end
      wr(A_CTRL, 16'h0001, r);
      for (int i = 0; i < 7; i++) begin
         c = (i == 0) ? 100 : (i == 1) ? 200 : (i == 2) ? 1000 : $urandom_range(1199);
         wr(A_CMD, 16'(c), r);
         wt(tgt(c), n);
      end
      $display("test clamp done");
      wr(A_CMD, 16'd400, r);
      wt(16'd400, n);
      wr(A_UPCT, 16'd60, r);
      wt(16'd360, n);
      cv("clamp_fast", 1, n < 8);
      load <= 1'b1;
      wr(A_UPCT, 16'd100, r);
      repeat (200) @(posedge clk_i);
      cv("load_hold", 360, freq_o);
      load <= 1'b0;
      wt(16'd400, n);
      rp(16'd300, 1);
      rp(16'd400, 1);
      wr(A_SACC, 16'h0001, r);
      rp(16'd500, 2);
      wr(A_SACC, 16'h0000, r);
      term <= 2'b10;
      rp(16'd600, 3);
      rd(A_STATUS, d, r);
      cv("pair2", 1, d[7]);
      term <= 2'b00;
      repeat (8) @(posedge clk_i);
      rp(16'd500, 1);
      wr(A_SDEC, 16'h0001, r);
      rp(16'd400, 2);
      wr(A_SDEC, 16'h0000, r);
      $display("test ramp done");
      wr(A_CTRL, 16'h0000, r);
      wt(16'h0, n);
      term <= 2'b01;
      wt(16'd200, n);
      rd(A_STATUS, d, r);
      cv("state", 4, d[3:0]);
      wr(A_CTRL, 16'h0003, r);
      repeat (100) @(posedge clk_i);
      cv("jog_freq", 200, freq_o);
      cv("dir", 1, dir_o);
      wr(A_CTRL, 16'h0002, r);
      term <= 2'b00;
      wt(16'h0, n);
      rd(A_STATUS, d, r);
      cv("state", 1, d[3:0]);
      $display("test jog done");
      test_done();
   end
endmodule // vfr_ramp_gen_tb
`default_nettype wire

//--- vfr_term_model.sv
`timescale 1ns/1ps
`default_nettype none
// command terminals and load sense ahead of the ramp block
module vfr_term_model (
   input  wire logic       clk_i,
   input  wire logic [1:0] term_req_i,
   input  wire logic       load_req_i,
   output var  logic [1:0] term_o,
   output var  logic       load_o
);
   initial term_o = 2'h0;
   initial load_o = 1'b0;
   always @(posedge clk_i) begin
      term_o <= term_req_i;
      load_o <= load_req_i;
   end
endmodule // vfr_term_model
`default_nettype wire
